/* File: verilog/uii_pkg.sv */
// Purpose: Shared constants and types for the serial port interrupt block
// Assumes: 32-bit APB, one word per register
// Notes: Offsets are byte addresses
package uii_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_INT_ENABLE = 8'h00;
  localparam logic [7:0] OFF_INT_IDENT = 8'h04;
  localparam logic [7:0] OFF_FIFO_CONTROL = 8'h08;
  localparam logic [7:0] OFF_FIFO_COPY = 8'h0c;
  localparam logic [7:0] OFF_MODEM_CONTROL = 8'h10;
  localparam logic [7:0] OFF_GENERAL_CONTROL = 8'h14;
  localparam logic [7:0] OFF_GENERAL_STATUS = 8'h18;
  localparam logic [7:0] OFF_SOURCE_STATUS = 8'h1c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int IE_RX_DATA = 0;
  localparam int IE_TX_EMPTY = 1;
  localparam int IE_LINE_STATUS = 2;
  localparam int IE_MODEM = 3;
  localparam int MCR_IRQ_GATE = 3;
  localparam int MCR_LOOPBACK = 4;
  localparam int FCR_FIFO_MODE = 0;
  localparam int GCR_PORT_ENABLE = 0;
  localparam int GCR_TX_TC_EN = 1;
  localparam int GCR_RX_TC_EN = 2;
  localparam int TC_TX = 0;
  localparam int TC_RX = 1;
  localparam int TC_BITS = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_INT_ENABLE = 4'h0;
  localparam logic [7:0] RST_FIFO_CONTROL = 8'h00;
  localparam logic [4:0] RST_MODEM_CONTROL = 5'h00;
  localparam logic [2:0] RST_GENERAL_CONTROL = 3'h0;
  localparam logic [1:0] RST_GENERAL_STATUS = 2'h0;

  // ---------------------------------------------------------------
  // Source codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CODE_MODEM = 3'h0;
  localparam logic [2:0] CODE_TX_EMPTY = 3'h1;
  localparam logic [2:0] CODE_RX_DATA = 3'h2;
  localparam logic [2:0] CODE_LINE_STATUS = 3'h3;
  localparam logic [2:0] CODE_TIMEOUT = 3'h6;

  // Raw source levels from the rest of the port
  typedef struct packed {
    logic line_status;
    logic rx_data;
    logic rx_timeout;
    logic tx_holding_empty;
    logic modem_change;
  } uii_src_t;

  typedef enum logic [1:0] {
    UII_IDLE,
    UII_ACCESS
  } uii_bus_t;

endpackage

/* File: verilog/uii_prio_enc.sv */
// Purpose: Registered priority encoder for the source code
// Assumes: Inputs already gated by enables
// Notes: Result appears one cycle after the inputs
module uii_prio_enc
  import uii_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input uii_src_t pend,
  input wire logic fifo_mode,
  output logic [2:0] int_source_code,
  output logic none_pending
);

  logic [2:0] code_d;
  logic none_d;

  // ---------------------------------------------------------------
  // Priority selection
  // ---------------------------------------------------------------
  always_comb begin
    code_d = CODE_MODEM;
    none_d = 1'b0;
    if (pend.line_status) begin
      code_d = CODE_LINE_STATUS;
    end else if (pend.rx_timeout && fifo_mode) begin
      code_d = CODE_TIMEOUT;
    end else if (pend.rx_data) begin
      code_d = CODE_RX_DATA;
    end else if (pend.tx_holding_empty) begin
      code_d = CODE_TX_EMPTY;
    end else if (pend.modem_change) begin
      code_d = CODE_MODEM;
    end else begin
      none_d = 1'b1;
    end
    if (!fifo_mode) begin
      code_d[2] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_source_code <= CODE_MODEM;
      none_pending <= 1'b1;
    end else begin
      int_source_code <= code_d;
      none_pending <= none_d;
    end
  end

  property p_line_first;
    @(posedge pclk) disable iff (!presetn)
    pend.line_status |=> (int_source_code == CODE_LINE_STATUS) && !none_pending;
  endproperty
  a_line_first: assert property (p_line_first) else $error("line status not first");

  property p_top_bit;
    @(posedge pclk) disable iff (!presetn)
    !fifo_mode |=> !int_source_code[2];
  endproperty
  a_top_bit: assert property (p_top_bit) else $error("top code bit set in single mode");

  property p_timeout_code;
    @(posedge pclk) disable iff (!presetn)
    fifo_mode && pend.rx_timeout && !pend.line_status |=> int_source_code == CODE_TIMEOUT;
  endproperty
  a_timeout_code: assert property (p_timeout_code) else $error("time-out code wrong");

endmodule

/* File: verilog/uii_top.sv */
// Purpose: Interrupt identification, priority and request gating of one serial port
// Assumes: Source levels come from logic on pclk; APB slave with one wait state
// Notes: Source code and request lag source levels by one cycle; request lags count events by two
// Functional notes
// - Four standard sources: data, empty, modem, line
// - Codes 000,001,010,011,110; others unused
// - Highest priority pending source is reported
// - Next read gives next pending source once the higher source's level drops
// - Data enable also enables time-out in FIFO mode
// - Single-buffer mode: code top bit zero
// - Enables in enable register, code in ident
// - DMA count events: sticky status, separate enables
// - Gate bit low forces request low
// - Loopback suppresses request
// - Port disabled after reset until software enables
// - Starts single-buffer; mode switchable any time
// - FIFO mode bit selects FIFO mode while the port is enabled
// - Control write-only; copy register reads it back
// - Raw source status always readable
module uii_top
  import uii_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input uii_src_t src,
  input wire logic tx_transfer_count_done,
  input wire logic rx_transfer_count_done,
  output logic irq,
  output logic fifo_mode,
  output logic loopback
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [3:0] int_enable_q, int_enable_d;
  logic [7:0] fifo_copy_q, fifo_copy_d;
  logic [4:0] modem_control_q, modem_control_d;
  logic [2:0] general_control_q, general_control_d;
  logic [TC_BITS-1:0] general_status_q, general_status_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic irq_d, fifo_mode_d, loopback_d;
  uii_bus_t bus_q, bus_d;

  logic [2:0] int_source_code;
  logic none_pending;
  uii_src_t pend;
  logic port_en, mode_fifo, irq_gate_enable, loop_sel;
  logic wr_en, rd_phase;
  logic [TC_BITS-1:0] tc_in, tc_en, tc_clr;

  assign port_en = general_control_q[GCR_PORT_ENABLE];
  assign mode_fifo = port_en && fifo_copy_q[FCR_FIFO_MODE];
  assign irq_gate_enable = modem_control_q[MCR_IRQ_GATE];
  assign loop_sel = modem_control_q[MCR_LOOPBACK];
  assign tc_in = {rx_transfer_count_done, tx_transfer_count_done};
  assign tc_en = {general_control_q[GCR_RX_TC_EN], general_control_q[GCR_TX_TC_EN]};

  // ---------------------------------------------------------------
  // Source gating
  // ---------------------------------------------------------------
  always_comb begin
    pend.line_status = port_en && src.line_status && int_enable_q[IE_LINE_STATUS];
    pend.rx_data = port_en && src.rx_data && int_enable_q[IE_RX_DATA];
    pend.rx_timeout = mode_fifo && src.rx_timeout && int_enable_q[IE_RX_DATA];
    pend.tx_holding_empty = port_en && src.tx_holding_empty && int_enable_q[IE_TX_EMPTY];
    pend.modem_change = port_en && src.modem_change && int_enable_q[IE_MODEM];
  end

  uii_prio_enc u_prio (
    .pclk(pclk),
    .presetn(presetn),
    .pend(pend),
    .fifo_mode(mode_fifo),
    .int_source_code(int_source_code),
    .none_pending(none_pending)
  );

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign rd_phase = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    bus_d = bus_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata;
    case (bus_q)
      UII_IDLE: begin
        if (rd_phase) begin
          bus_d = UII_ACCESS;
          pready_d = 1'b1;
          prdata_d = 32'h0000_0000;
          if (paddr == OFF_INT_ENABLE) begin
            prdata_d[3:0] = int_enable_q;
          end else if (paddr == OFF_INT_IDENT) begin
            prdata_d[3:0] = {int_source_code, none_pending};
          end else if (paddr == OFF_FIFO_CONTROL) begin
            prdata_d = 32'h0000_0000;
          end else if (paddr == OFF_FIFO_COPY) begin
            prdata_d[7:0] = fifo_copy_q;
          end else if (paddr == OFF_MODEM_CONTROL) begin
            prdata_d[4:0] = modem_control_q;
          end else if (paddr == OFF_GENERAL_CONTROL) begin
            prdata_d[2:0] = general_control_q;
          end else if (paddr == OFF_GENERAL_STATUS) begin
            prdata_d[TC_BITS-1:0] = general_status_q;
          end else if (paddr == OFF_SOURCE_STATUS) begin
            prdata_d[4:0] = src;
          end else begin
            pslverr_d = 1'b1;
          end
        end
      end
      UII_ACCESS: begin
        bus_d = UII_IDLE;
      end
      default: begin
        bus_d = UII_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_comb begin
    int_enable_d = int_enable_q;
    fifo_copy_d = fifo_copy_q;
    modem_control_d = modem_control_q;
    general_control_d = general_control_q;
    tc_clr = '0;
    if (wr_en) begin
      if (paddr == OFF_INT_ENABLE) begin
        int_enable_d = pwdata[3:0];
      end else if (paddr == OFF_FIFO_CONTROL) begin
        fifo_copy_d = pwdata[7:0];
      end else if (paddr == OFF_MODEM_CONTROL) begin
        modem_control_d = pwdata[4:0];
      end else if (paddr == OFF_GENERAL_CONTROL) begin
        general_control_d = pwdata[2:0];
      end else if (paddr == OFF_GENERAL_STATUS) begin
        tc_clr = pwdata[TC_BITS-1:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < TC_BITS; gi++) begin : g_tc
      always_comb begin
        general_status_d[gi] = tc_in[gi] || (general_status_q[gi] && !tc_clr[gi]);
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Request and mode outputs
  // ---------------------------------------------------------------
  always_comb begin
    irq_d = irq_gate_enable && !loop_sel && ((|pend) || (|(general_status_q & tc_en)));
    fifo_mode_d = mode_fifo;
    loopback_d = loop_sel;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_q <= UII_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      int_enable_q <= RST_INT_ENABLE;
      fifo_copy_q <= RST_FIFO_CONTROL;
      modem_control_q <= RST_MODEM_CONTROL;
      general_control_q <= RST_GENERAL_CONTROL;
      general_status_q <= RST_GENERAL_STATUS;
      irq <= 1'b0;
      fifo_mode <= 1'b0;
      loopback <= 1'b0;
    end else begin
      bus_q <= bus_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      prdata <= prdata_d;
      int_enable_q <= int_enable_d;
      fifo_copy_q <= fifo_copy_d;
      modem_control_q <= modem_control_d;
      general_control_q <= general_control_d;
      general_status_q <= general_status_d;
      irq <= irq_d;
      fifo_mode <= fifo_mode_d;
      loopback <= loopback_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_fcr_write;
    wr_en && paddr == OFF_FIFO_CONTROL;
  endsequence

  property p_gate_low;
    @(posedge pclk) disable iff (!presetn)
    !irq_gate_enable |=> !irq;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("request passed closed gate");

  property p_loop_off;
    @(posedge pclk) disable iff (!presetn)
    loop_sel |=> !irq;
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("request in loopback");

  property p_irq_src;
    @(posedge pclk) disable iff (!presetn)
    irq_gate_enable && !loop_sel && general_status_q[TC_RX] && tc_en[TC_RX] |=> irq;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("count event gave no request");

  property p_tc_sticky;
    @(posedge pclk) disable iff (!presetn)
    tx_transfer_count_done ##1 !tx_transfer_count_done && !tc_clr[TC_TX] |=> general_status_q[TC_TX];
  endproperty
  a_tc_sticky: assert property (p_tc_sticky) else $error("count flag not sticky");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    rx_transfer_count_done && tc_clr[TC_RX] |=> general_status_q[TC_RX];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_copy;
    @(posedge pclk) disable iff (!presetn)
    s_fcr_write |=> fifo_copy_q == $past(pwdata[7:0]);
  endproperty
  a_copy: assert property (p_copy) else $error("copy register stale");

  property p_mode;
    @(posedge pclk) disable iff (!presetn)
    s_fcr_write ##1 port_en |=> fifo_mode == fifo_copy_q[FCR_FIFO_MODE];
  endproperty
  a_mode: assert property (p_mode) else $error("mode not following bit");

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
    !port_en [*2] |-> none_pending && !fifo_mode;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled port reports source");

  property p_ident_rd;
    @(posedge pclk) disable iff (!presetn)
    rd_phase && paddr == OFF_INT_IDENT |=> prdata[3:0] == $past({int_source_code, none_pending}) && prdata[31:4] == 28'h0;
  endproperty
  a_ident_rd: assert property (p_ident_rd) else $error("ident read data wrong");

  property p_raw_rd;
    @(posedge pclk) disable iff (!presetn)
    rd_phase && paddr == OFF_SOURCE_STATUS |=> prdata[4:0] == $past(src);
  endproperty
  a_raw_rd: assert property (p_raw_rd) else $error("raw source levels not readable");

  property p_fcr_rd;
    @(posedge pclk) disable iff (!presetn)
    rd_phase && paddr == OFF_FIFO_CONTROL |=> prdata == 32'h0000_0000;
  endproperty
  a_fcr_rd: assert property (p_fcr_rd) else $error("write-only control read back");

  property p_no_timeout;
    @(posedge pclk) disable iff (!presetn)
    !int_enable_q[IE_RX_DATA] |=> int_source_code != CODE_TIMEOUT;
  endproperty
  a_no_timeout: assert property (p_no_timeout) else $error("time-out without data enable");

  property p_std_irq;
    @(posedge pclk) disable iff (!presetn)
    irq_gate_enable && !loop_sel && pend.tx_holding_empty |=> irq;
  endproperty
  a_std_irq: assert property (p_std_irq) else $error("enabled source gave no request");

endmodule

/* File: test/uii_pic_model.sv */
// Purpose: Interrupt controller stand-in on the serial port request line
// Assumes: Request is a level on pclk
// Notes: Counts rising edges of the request it receives
module uii_pic_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq,
  output logic [7:0] edge_count
);
  timeunit 1ns;
  timeprecision 1ps;

  logic irq_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      edge_count <= 8'h00;
    end else begin
      irq_q <= irq;
      if (irq && !irq_q) begin
        edge_count <= edge_count + 8'h01;
      end
    end
  end
endmodule

/* File: test/uii_top_test.sv */
// Purpose: Self-checking bench for the interrupt ident and gating block
// Assumes: APB master tasks; source levels driven on pclk
// Notes: Waits of three cycles cover the one-cycle source to request path
module uii_top_test;
  import uii_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  uii_src_t src;
  logic tx_tc;
  logic rx_tc;
  logic irq;
  logic fifo_mode;
  logic loopback;
  logic [7:0] edge_count;
  int fail_count;
  int checks;
  int cycles;
  logic [31:0] r;
  logic e;
  logic [4:0] v;
  logic [2:0] codes [4];
  logic [4:0] clr [4];

  uii_top uii_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
    .tx_transfer_count_done(tx_tc), .rx_transfer_count_done(rx_tc), .irq(irq), .fifo_mode(fifo_mode),
    .loopback(loopback));

  uii_pic_model uii_pic_model_i (.pclk(pclk), .presetn(presetn), .irq(irq), .edge_count(edge_count));

  // ---------------------------------------------------------------
  // Clock, timeout and report
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test;
    end
  end

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  task settle;
    repeat (3) @(posedge pclk);
  endtask

  task set_src(input logic [4:0] s);
    @(posedge pclk);
    src <= uii_src_t'(s);
    settle;
  endtask

  task pulse(input logic tx_sel);
    @(posedge pclk);
    if (tx_sel) begin
      tx_tc <= 1'b1;
    end else begin
      rx_tc <= 1'b1;
    end
    @(posedge pclk);
    tx_tc <= 1'b0;
    rx_tc <= 1'b0;
    settle;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src = '0;
    tx_tc = 1'b0;
    rx_tc = 1'b0;
    fail_count = 0;
    checks = 0;
    cycles = 0;
    codes = '{CODE_LINE_STATUS, CODE_RX_DATA, CODE_TX_EMPTY, CODE_MODEM};
    clr = '{5'h10, 5'h08, 5'h02, 5'h01};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_INT_ENABLE, 32'h0);
    rd(OFF_MODEM_CONTROL, 32'h0);
    rd(OFF_GENERAL_CONTROL, 32'h0);
    rd(OFF_GENERAL_STATUS, 32'h0);
    rd(OFF_INT_IDENT, 32'h1);
    chk({31'h0, fifo_mode}, 32'h0);
    rd(8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(OFF_INT_ENABLE, 32'hf);
    set_src(5'h1f);
    rd(OFF_INT_IDENT, 32'h1);
    rd(OFF_SOURCE_STATUS, 32'h1f);
    wr(OFF_GENERAL_CONTROL, 32'h1);
    v = 5'h1b;
    for (int i = 0; i < 4; i++) begin
      set_src(v);
      rd(OFF_INT_IDENT, {28'h0, codes[i], 1'b0});
      v = v & ~clr[i];
    end
    set_src(5'h04);
    rd(OFF_INT_IDENT, 32'h1);
    wr(OFF_FIFO_CONTROL, 32'h1);
    settle;
    chk({31'h0, fifo_mode}, 32'h1);
    rd(OFF_INT_IDENT, {28'h0, CODE_TIMEOUT, 1'b0});
    rd(OFF_FIFO_CONTROL, 32'h0);
    rd(OFF_FIFO_COPY, 32'h1);
    set_src(5'h14);
    rd(OFF_INT_IDENT, {28'h0, CODE_LINE_STATUS, 1'b0});
    wr(OFF_INT_ENABLE, 32'ha);
    settle;
    rd(OFF_INT_IDENT, 32'h1);
    wr(OFF_INT_ENABLE, 32'hf);
    wr(OFF_FIFO_CONTROL, 32'h0);
    set_src(5'h02);
    chk({31'h0, fifo_mode}, 32'h0);
    rd(OFF_INT_IDENT, {28'h0, CODE_TX_EMPTY, 1'b0});
    chk({31'h0, irq}, 32'h0);
    wr(OFF_MODEM_CONTROL, 32'h8);
    settle;
    chk({31'h0, irq}, 32'h1);
    chk({24'h0, edge_count}, 32'h1);
    wr(OFF_MODEM_CONTROL, 32'h18);
    settle;
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, loopback}, 32'h1);
    wr(OFF_MODEM_CONTROL, 32'h8);
    wr(OFF_INT_ENABLE, 32'h0);
    settle;
    chk({31'h0, irq}, 32'h0);
    rd(OFF_SOURCE_STATUS, 32'h02);
    set_src(5'h00);
    wr(OFF_GENERAL_CONTROL, 32'h3);
    pulse(1'b1);
    rd(OFF_GENERAL_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    pulse(1'b0);
    rd(OFF_GENERAL_STATUS, 32'h3);
    wr(OFF_GENERAL_STATUS, 32'h1);
    settle;
    rd(OFF_GENERAL_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_GENERAL_CONTROL, 32'h5);
    settle;
    chk({31'h0, irq}, 32'h1);
    @(posedge pclk);
    rx_tc <= 1'b1;
    wr(OFF_GENERAL_STATUS, 32'h2);
    @(posedge pclk);
    rx_tc <= 1'b0;
    settle;
    rd(OFF_GENERAL_STATUS, 32'h2);
    wr(OFF_GENERAL_STATUS, 32'h2);
    settle;
    rd(OFF_GENERAL_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    end_of_test;
  end
endmodule
